// [rtl/rshd_pkg.sv]
// Purpose: constants and types for the reset strap and host decode block
// Assumes: 25 MHz device clock, straps sampled from the memory data pins
package rshd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // strap field positions within the captured 16-bit memory data word
  localparam int STRAP_W = 16;
  localparam int STRAP_NV_HI = 15;  // nv_type_hi_strap
  localparam int STRAP_NV_LO = 14;  // nv_type_lo_strap
  localparam int STRAP_SHI = 13;    // serial host select, parallel off
  localparam int STRAP_ISA = 7;     // isa_bus_select
  localparam int STRAP_IOCFG = 6;   // io_space_cfg_decode strap
  localparam logic [15:0] STRAP_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // card configuration register offsets, io and attribute space alike
  localparam logic [7:0] CFG_OPT_OFS = 8'h40;    // card_config_option
  localparam logic [7:0] CFG_STAT_OFS = 8'h42;   // card_config_status
  localparam logic [7:0] PIN_REPL_OFS = 8'h44;   // pin_replacement
  localparam int CFG_OPT_SRESET = 7;             // software reset bit
  localparam logic [7:0] CFG_OPT_RST = 8'h00;
  localparam logic [7:0] CFG_STAT_RST = 8'h00;
  localparam logic [7:0] PIN_REPL_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // register index returned by the address decoder
  localparam logic [1:0] IDX_OPT = 2'h0;
  localparam logic [1:0] IDX_STAT = 2'h1;
  localparam logic [1:0] IDX_PREP = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // serial memory clock timing
  localparam int CLK_MHZ = 25;
  localparam int NV_CLK_PERIOD_NS = 2500;  // 400 kHz
  localparam int NV_HALF_NS = NV_CLK_PERIOD_NS / 2;
  // least half period, rounded up so the rate never exceeds 400 kHz
  localparam int NV_HALF_CYC = (NV_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int NV_CNT_W = 6;
  localparam logic [5:0] NV_HALF_LAST = 6'(NV_HALF_CYC - 1);
  localparam logic [5:0] NV_CNT_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // startup sequence states
  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_LOAD_FW,
    ST_LOAD_CIS,
    ST_RUN,
    ST_HOST_WAIT,
    ST_NO_NV
  } rshd_boot_t;

endpackage : rshd_pkg

// [rtl/rshd_nv_if.sv]
// Purpose: carrier between startup control and serial clock generator
// Assumes: one clock domain
// Notes: ctrl enables the clock, gen produces it
`timescale 1ns/1ps
interface rshd_nv_if;
  logic en;    // serial clock runs while high
  logic sclk;  // serial memory clock, registered
  modport ctrl (output en, input sclk);
  modport gen (input en, output sclk);
endinterface : rshd_nv_if

// [rtl/rshd_serclk.sv]
// Purpose: serial nonvolatile memory clock divider
// Assumes: rst_n already synchronised, ce freezes the divider
// Notes: half period rounds up, so the rate sits just under 400 kHz
`timescale 1ns/1ps
module rshd_serclk
  import rshd_pkg::*;
(
  // clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_n,
  // link to control
  rshd_nv_if.gen nv
);

  // divider state
  typedef struct packed {
    logic [NV_CNT_W-1:0] cnt;  // cycles into current half period
    logic sclk;                // clock level
  } rshd_sc_st_t;

  rshd_sc_st_t q;
  rshd_sc_st_t d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: idle low when disabled so the memory sees a clean stop
  always_comb begin
    d = q;
    if (!nv.en) begin
      d.cnt = NV_CNT_RST;
      d.sclk = 1'b0;
    end else if (q.cnt == NV_HALF_LAST) begin
      d.cnt = NV_CNT_RST;
      d.sclk = ~q.sclk;
    end else begin
      d.cnt = q.cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{cnt: NV_CNT_RST, sclk: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign nv.sclk = q.sclk;

endmodule : rshd_serclk

// [rtl/rshd_top.sv]
// Purpose: reset strap capture, config register decode, startup select
// Assumes: host strobes and memory data pins synchronous to clk
// Notes: straps are re-taken while the software reset bit is set
`timescale 1ns/1ps
module rshd_top
  import rshd_pkg::*;
(
  // clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rstn,
  // memory bus data pins, strap source
  input wire logic [15:0] md_in,
  // host register access
  input wire logic host_req,
  input wire logic host_wr,
  input wire logic host_io,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_ack,
  output logic host_hit,
  // decode status
  output logic io_space_cfg_decode,
  output logic attr_space_en,
  output logic isa_bus_select,
  output logic parallel_host_enable,
  output logic soft_reset,
  // startup sequence
  input wire logic nv_load_done,
  output logic nv_load_req,
  output logic nv_fw_copy,
  output logic nv_cis_only,
  output logic nv_unsupported,
  output logic host_wait,
  output logic nv_sclk,
  output logic [1:0] serial_nv_type
);

  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser: release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else if (ce) begin
      // gated by ce so a frozen block also holds its reset release
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // block state
  typedef struct packed {
    logic [STRAP_W-1:0] strap;  // captured straps
    logic cap_pend;             // first cycle after release takes straps
    rshd_boot_t st;             // startup sequence state
    logic [7:0] cfg_opt;        // card_config_option
    logic [7:0] cfg_stat;       // card_config_status
    logic [7:0] pin_repl;       // pin_replacement
    logic [7:0] rdata;          // read answer
    logic ack;                  // access done pulse
    logic hit;                  // access landed on a register
    logic io_dec;               // effective io decode
    logic attr_en;              // attribute space open
    logic isa_on;               // effective isa_bus_select
    logic phi_on;               // parallel host on
    logic load_req;             // serial memory load running
    logic fw_copy;              // large part selected
    logic cis_only;             // small part selected
    logic unsup;                // no supported serial memory
    logic hwait;                // idle, waiting for host
  } rshd_top_st_t;

  rshd_top_st_t q;
  rshd_top_st_t d;

  rshd_nv_if nv_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // offset decoder, shared by read and write paths
  function automatic logic [1:0] fcr_index(input logic [7:0] a);
    case (a)
      CFG_OPT_OFS: fcr_index = IDX_OPT;
      CFG_STAT_OFS: fcr_index = IDX_STAT;
      PIN_REPL_OFS: fcr_index = IDX_PREP;
      default: fcr_index = IDX_NONE;
    endcase
  endfunction : fcr_index

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic srst;
    logic allowed;
    logic [1:0] rd_idx;
    logic [1:0] wr_idx;
    srst = 1'b0;
    allowed = 1'b0;
    rd_idx = IDX_NONE;
    wr_idx = IDX_NONE;
    d = q;
    srst = q.cfg_opt[CFG_OPT_SRESET];

    // straps follow the pins only in the cap_pend cycle and while the soft reset bit is set
    if (q.cap_pend || srst) begin
      d.strap = md_in;
      d.cap_pend = 1'b0;
      d.st = ST_CAPTURE;
    end
    // otherwise strap stays put whatever the pins do

    // decode settings from the held straps
    d.phi_on = ~q.strap[STRAP_SHI];
    d.isa_on = d.phi_on & q.strap[STRAP_ISA];
    // phi off disregards the strap, isa forces it on
    d.io_dec = d.phi_on & (d.isa_on | q.strap[STRAP_IOCFG]);
    d.attr_en = ~d.isa_on;

    // startup selection from the serial memory type straps
    case (q.st)
      ST_CAPTURE: begin
        if (!srst && !q.cap_pend) begin
          if (q.strap[STRAP_NV_HI]) begin
            d.st = ST_NO_NV;
          end else if (q.strap[STRAP_NV_LO]) begin
            d.st = ST_LOAD_CIS;
          end else begin
            d.st = ST_LOAD_FW;
          end
        end
      end
      ST_LOAD_FW: begin
        if (nv_load_done && !srst) begin
          d.st = ST_RUN;
        end
      end
      ST_LOAD_CIS: begin
        if (nv_load_done && !srst) begin
          d.st = ST_HOST_WAIT;
        end
      end
      ST_RUN, ST_HOST_WAIT, ST_NO_NV: begin
        // stay until a reset restarts the sequence
      end
      default: begin
        d.st = ST_CAPTURE;
      end
    endcase
    d.load_req = (d.st == ST_LOAD_FW) || (d.st == ST_LOAD_CIS);
    d.fw_copy = (d.st == ST_LOAD_FW) || (d.st == ST_RUN);
    d.cis_only = (d.st == ST_LOAD_CIS) || (d.st == ST_HOST_WAIT);
    d.unsup = (d.st == ST_NO_NV);
    d.hwait = (d.st == ST_HOST_WAIT);

    // host access: io needs the io decode, attribute needs it open
    d.ack = 1'b0;
    d.hit = 1'b0;
    if (host_req) begin
      d.ack = 1'b1;
      allowed = host_io ? q.io_dec : q.attr_en;
      rd_idx = allowed ? fcr_index(host_addr) : IDX_NONE;
      wr_idx = (allowed && host_wr) ? fcr_index(host_addr) : IDX_NONE;
      d.hit = (rd_idx != IDX_NONE);
      // reads return zero on a miss, writes are dropped
      case (rd_idx)
        IDX_OPT: d.rdata = q.cfg_opt;
        IDX_STAT: d.rdata = q.cfg_stat;
        IDX_PREP: d.rdata = q.pin_repl;
        default: d.rdata = UNMAPPED_RD;
      endcase
      case (wr_idx)
        IDX_OPT: d.cfg_opt = host_wdata;
        IDX_STAT: d.cfg_stat = host_wdata;
        IDX_PREP: d.pin_repl = host_wdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{strap: STRAP_RST, cap_pend: 1'b1, st: ST_CAPTURE,
             cfg_opt: CFG_OPT_RST, cfg_stat: CFG_STAT_RST,
             pin_repl: PIN_REPL_RST, rdata: UNMAPPED_RD, default: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock, runs only during a load
  assign nv_bus.en = q.load_req;

  rshd_serclk u_serclk (
    .clk(clk),
    .ce(ce),
    .rst_n(rst_n),
    .nv(nv_bus.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign host_rdata = q.rdata;
  assign host_ack = q.ack;
  assign host_hit = q.hit;
  assign io_space_cfg_decode = q.io_dec;
  assign attr_space_en = q.attr_en;
  assign isa_bus_select = q.isa_on;
  assign parallel_host_enable = q.phi_on;
  assign soft_reset = q.cfg_opt[CFG_OPT_SRESET];
  assign nv_load_req = q.load_req;
  assign nv_fw_copy = q.fw_copy;
  assign nv_cis_only = q.cis_only;
  assign nv_unsupported = q.unsup;
  assign host_wait = q.hwait;
  assign nv_sclk = nv_bus.sclk;
  assign serial_nv_type = q.strap[STRAP_NV_HI:STRAP_NV_LO];

endmodule : rshd_top

// [testbench/rshd_top_properties.sv]
// Purpose: port-level checks for the strap and host decode block
// Assumes: ce held high, one clock domain
// Notes: bound to rshd_top at the foot of this file
`timescale 1ns/1ps
module rshd_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host access
  input wire logic host_req,
  input wire logic host_io,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_rdata,
  input wire logic host_ack,
  input wire logic host_hit,
  // decode status
  input wire logic io_space_cfg_decode,
  input wire logic attr_space_en,
  input wire logic isa_bus_select,
  input wire logic parallel_host_enable,
  input wire logic soft_reset,
  // startup
  input wire logic nv_load_done,
  input wire logic nv_load_req,
  input wire logic nv_fw_copy,
  input wire logic nv_cis_only,
  input wire logic host_wait,
  input wire logic nv_sclk,
  input wire logic [1:0] serial_nv_type
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  logic last_q;  // serial clock one cycle ago
  logic [6:0] cnt_q;  // samples since the serial clock last changed
  // a repetition cannot span 32 cycles, so the half period is counted here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 1'b0;
      cnt_q <= 7'h00;
    end else begin
      last_q <= nv_sclk;
      cnt_q <= (nv_sclk != last_q) ? 7'h01 : cnt_q + 7'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cis_end;  // small part finishes its load
    nv_load_req && nv_cis_only && nv_load_done && !soft_reset;
  endsequence
  sequence s_waiting;  // load over, idle for the host
    !nv_load_req && host_wait;
  endsequence
  sequence s_quiet;  // settled after startup, no soft reset
    (host_wait || nv_fw_copy) && !soft_reset ##1 !soft_reset;
  endsequence
  sequence s_still;  // straps and decode unchanged
    $stable(serial_nv_type) && $stable(io_space_cfg_decode);
  endsequence
  sequence s_io_cfg;  // io access to one of the three config offsets
    host_req && host_io && io_space_cfg_decode &&
    (host_addr == 8'h40 || host_addr == 8'h42 || host_addr == 8'h44);
  endsequence
  sequence s_io_off;  // io access while io decode is closed
    host_req && host_io && !io_space_cfg_decode;
  endsequence
  sequence s_miss;  // refused access answer
    !host_hit && host_rdata == 8'h00;
  endsequence
  sequence s_no_io;  // neither io decode nor isa_bus_select
    !io_space_cfg_decode && !isa_bus_select;
  endsequence
  sequence s_isa;  // isa_bus_select decode pair
    io_space_cfg_decode && !attr_space_en;
  endsequence
  sequence s_attr_isa;  // attribute access in isa_bus_select
    host_req && !host_io && isa_bus_select;
  endsequence
  sequence s_large_load;  // load running for type 00
    nv_load_req && serial_nv_type == 2'h0;
  endsequence
  sequence s_fall;  // serial clock falls inside a load
    $fell(nv_sclk) && nv_load_req;
  endsequence
  sequence s_idle2;  // no load for two samples
    !nv_load_req ##1 !nv_load_req;
  endsequence
  AST_ACK: assert property (host_req |=> host_ack)
    else $error("no acknowledge after request");
  AST_IO_HIT: assert property (s_io_cfg |=> host_hit)
    else $error("io config access missed");
  AST_IO_MISS: assert property (s_io_off |=> s_miss)
    else $error("io access hit while io decode off");
  AST_PHI_OFF: assert property (!parallel_host_enable |-> s_no_io)
    else $error("io decode kept with parallel host off");
  AST_ISA_IO: assert property (isa_bus_select |-> s_isa)
    else $error("isa_bus_select without io decode");
  AST_ISA_ATTR: assert property (s_attr_isa |=> !host_hit)
    else $error("attribute hit in isa_bus_select");
  AST_FW: assert property (s_large_load |-> nv_fw_copy)
    else $error("large part not on copy path");
  AST_CIS_END: assert property (s_cis_end |=> s_waiting)
    else $error("no host wait after small load");
  AST_NO_NV: assert property (serial_nv_type[1] |-> !nv_load_req)
    else $error("load started for unsupported type");
  AST_SCLK_HALF: assert property (s_fall |-> cnt_q == 7'h20)
    else $error("serial clock half period");
  AST_SCLK_IDLE: assert property (s_idle2 |-> !nv_sclk)
    else $error("serial clock runs while idle");
  AST_HOLD: assert property (s_quiet |-> s_still)
    else $error("straps moved");
endmodule : rshd_props
bind rshd_top rshd_props u_rshd_props (.clk, .rstn, .host_req, .host_io,
  .host_addr, .host_rdata, .host_ack, .host_hit, .io_space_cfg_decode,
  .attr_space_en, .isa_bus_select, .parallel_host_enable, .soft_reset,
  .nv_load_done, .nv_load_req, .nv_fw_copy, .nv_cis_only, .host_wait,
  .nv_sclk, .serial_nv_type);

// [testbench/rshd_nvmem_model.sv]
// Purpose: serial memory loader standing on the far side of startup
// Assumes: done is judged by serial clock rises seen on clk
// Notes: done stays up until the load request drops
`timescale 1ns/1ps
module rshd_nvmem_model #(parameter int RISES = 2) (
  // clock
  input wire logic clk,
  // from startup control
  input wire logic nv_load_req,
  input wire logic nv_sclk,
  // back to startup control
  output logic nv_load_done
);
  int rise_n = 0;  // serial clock rises during this load
  logic last = 1'b0;  // previous serial clock level
  // count real serial clock rises so a stuck clock never finishes a load
  always @(posedge clk) begin
    last <= nv_sclk;
    if (!nv_load_req) rise_n <= 0;
    else if (nv_sclk && !last) rise_n <= rise_n + 1;
  end
  assign nv_load_done = nv_load_req && (rise_n >= RISES);
endmodule : rshd_nvmem_model

// [testbench/test_rshd_top.sv]
// Purpose: directed bench for strap capture, decode and startup
// Assumes: inputs change on the falling edge, ce tied high
// Notes: md_in is flipped after boot to prove the straps hold
`timescale 1ns/1ps
module test_rshd_top;
  logic clk = 1'b0, rstn = 1'b0, host_req = 1'b0, host_wr = 1'b0;
  logic host_io = 1'b0, host_ack, host_hit, io_space_cfg_decode;
  logic [15:0] md_in = 16'h0000;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata;
  logic attr_space_en, isa_bus_select, parallel_host_enable, soft_reset;
  logic nv_load_done, nv_load_req, nv_fw_copy, nv_cis_only;
  logic nv_unsupported, host_wait, nv_sclk;
  logic [1:0] serial_nv_type;
  int mismatches = 0, comparisons = 0;
  logic [15:0] tbl [8] = '{16'h0040, 16'h0000, 16'h00C0, 16'h2040,
    16'h20C0, 16'h4000, 16'h8040, 16'hC000};
  rshd_top u_rshd_top (.clk, .ce(1'b1), .rstn, .md_in, .host_req, .host_wr,
    .host_io, .host_addr, .host_wdata, .host_rdata, .host_ack, .host_hit,
    .io_space_cfg_decode, .attr_space_en, .isa_bus_select,
    .parallel_host_enable, .soft_reset, .nv_load_done, .nv_load_req,
    .nv_fw_copy, .nv_cis_only, .nv_unsupported, .host_wait, .nv_sclk,
    .serial_nv_type);
  rshd_nvmem_model u_rshd_nvmem_model (.clk, .nv_load_req, .nv_sclk,
    .nv_load_done);
  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one host access, request held over the edge that takes it
  task automatic acc(input logic wr, input logic io, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] rd, output logic hit);
    @(negedge clk);
    {host_req, host_wr, host_io, host_addr, host_wdata} = {1'b1, wr, io, a, d};
    @(negedge clk);
    host_req = 1'b0;
    chk({7'h00, host_ack}, 8'h01);
    rd = host_rdata;
    hit = host_hit;
  endtask : acc
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [15:0] md;
    logic p, i, io, hit;
    logic [7:0] rd;
    int n;
    for (int k = 0; k < 8; k++) begin
      md = tbl[k];
      rstn = 1'b0;
      md_in = md;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      p = !md[13];
      i = p & md[7];
      io = p & (i | md[6]);
      md_in = ~md;  // later pin activity must not reach the straps
      chk({6'h00, serial_nv_type}, {6'h00, md[15:14]});
      chk({7'h00, parallel_host_enable}, {7'h00, p});
      chk({7'h00, io_space_cfg_decode}, {7'h00, io});
      chk({6'h00, isa_bus_select, attr_space_en}, {6'h00, i, !i});
      acc(1'b1, 1'b1, 8'h42, 8'hA5, rd, hit);
      chk({7'h00, hit}, {7'h00, io});
      acc(1'b0, 1'b1, 8'h42, 8'h00, rd, hit);
      chk(rd, io ? 8'hA5 : 8'h00);
      acc(1'b0, 1'b0, 8'h42, 8'h00, rd, hit);
      chk(rd, (io && !i) ? 8'hA5 : 8'h00);
      acc(1'b0, 1'b1, 8'h41, 8'h00, rd, hit);
      chk({7'h00, hit}, 8'h00);
      // the load is still running here for the supported types
      chk({7'h00, nv_load_req}, {7'h00, !md[15]});
      chk({7'h00, nv_cis_only}, {7'h00, md[15:14] == 2'h1});
      for (n = 0; n < 400 && nv_load_req; n++) @(negedge clk);
      if (n == 400) begin
        mismatches++;
        summarize();
      end
      chk({7'h00, nv_fw_copy}, {7'h00, md[15:14] == 2'h0});
      chk({7'h00, host_wait}, {7'h00, md[15:14] == 2'h1});
      chk({7'h00, nv_unsupported}, {7'h00, md[15]});
      chk({6'h00, serial_nv_type}, {6'h00, md[15:14]});
      $display("test %0d done", k);
    end
    md_in = 16'h0040;  // soft reset retakes the straps
    acc(1'b1, 1'b0, 8'h40, 8'h80, rd, hit);
    chk({7'h00, soft_reset}, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, nv_load_req}, 8'h00);
    chk({6'h00, serial_nv_type}, 8'h00);
    acc(1'b1, 1'b0, 8'h40, 8'h00, rd, hit);
    md_in = 16'h2000;
    repeat (4) @(negedge clk);
    chk({6'h00, io_space_cfg_decode, parallel_host_enable}, 8'h03);
    $display("test soft reset done");
    summarize();
  end
endmodule : test_rshd_top
